// ---- shared/dsh_cfg.svh ----
// Offsets, field positions and reset values of the debug status holding registers
// What this block does
// - Set the trace flag when a single-step command is first recognised.
// - Trace flag stays set until a resume or resume-until command exits; here a status write also loads it from data bit 3.
// - While secured, only secure firmware in special mode may write the unsecure flag.
// - Unsecure flag is zero on secure entry; secure table then overlays standard table (here only in special mode; normal mode locks without it).
// - Erased flash: set unsecure flag, jump to standard table, drop secure table (here only in special mode; a normal-mode lock ignores erase results).
// - Failed erase verify leaves the unsecure flag clear.
// - Unsecure flag reads 0 when secured and 1 when unsecured; here it reads 0 with flash security off unless a status write sets it.
// - Unsecured state lasts until next reset unless flash security bits change; here only a status write clearing bit 1 ends it before reset.
// - On debug entry the CPU flags are copied into the holding register.
// - Holding register resets to d8 in special mode, zero in other modes.
// - Holding register is writable so the debugger can alter restored flags.
// - Holding and page registers reachable only by debug accesses when unsecured.
// - Page enable set means debug accesses use program paging, clear means not.
// - Debug register commands never make global accesses, whatever global enable says.
// - Four-bit page index selects the program page of paged debug accesses.
// - Debug registers readable by the debug unit only, never by user programs.
`ifndef DSH_CFG_SVH
`define DSH_CFG_SVH

// =====================================================================
// Register map
`define DSH_ADDR_W        18
`define DSH_OFS_STATUS    18'h3ff01
`define DSH_OFS_HOLD      18'h3ff06
`define DSH_OFS_PAGE      18'h3ff08

// =====================================================================
// Field positions
`define DSH_TRACE_BIT     3
`define DSH_UNSECURE_FLAG_BIT     1
`define DSH_PAGE_EN_BIT   7
`define DSH_PAGE_IDX_W    4

// =====================================================================
// Reset values
`define DSH_HOLD_RST_SPC  8'hd8
`define DSH_HOLD_RST_OTH  8'h00
`define DSH_CPU_FLAGS_SPC 8'hd0

`endif

// ---- shared/dsh_pkg.sv ----
// Types shared by the debug status holding register block
package dsh_pkg;
    // Security walk; Gray along reset -> verify -> unsecured
    typedef enum logic [2:0] {
        DSH_S_INIT   = 3'h0,
        DSH_S_VERIFY = 3'h1,
        DSH_S_UNSECURE_FLAG  = 3'h3,
        DSH_S_OPEN   = 3'h2,
        DSH_S_LOCK   = 3'h5
    } dsh_sec_state_t;
endpackage

// ---- shared/dsh_reg_if.sv ----
// Write strobes and register state between the top and its register slices
`timescale 1ns/1ps
interface dsh_reg_if;
    logic       ce;
    logic [7:0] wdata;
    logic       stat_we;
    logic       page_we;
    logic       trace_set;
    logic       trace_clr;
    logic       unsecure_flag_set;
    logic       trace;
    logic       unsecure_flag;
    logic       page_en;
    logic [3:0] page_idx;

    modport ctl  (output ce, wdata, stat_we, page_we, trace_set, trace_clr, unsecure_flag_set,
                  input trace, unsecure_flag, page_en, page_idx);
    modport stat (input ce, wdata, stat_we, trace_set, trace_clr, unsecure_flag_set,
                  output trace, unsecure_flag);
    modport page (input ce, wdata, page_we, output page_en, page_idx);
endinterface

// ---- core/dsh_status.sv ----
// Trace and unsecure flags of the debug status register
`timescale 1ns/1ps
`include "dsh_cfg.svh"
module dsh_status
    import dsh_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    dsh_reg_if.stat   bus
);
    // Trace flag; a new single-step wins over any clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.trace <= 1'b0;
        end else if (bus.ce) begin
            if (bus.trace_set) begin
                bus.trace <= 1'b1;
            end else if (bus.stat_we) begin
                bus.trace <= bus.wdata[`DSH_TRACE_BIT];
            end else if (bus.trace_clr) begin
                bus.trace <= 1'b0;
            end
        end
    end

    // Unsecure flag; zero after every reset so security returns
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.unsecure_flag <= 1'b0;
        end else if (bus.ce) begin
            if (bus.unsecure_flag_set) begin
                bus.unsecure_flag <= 1'b1;
            end else if (bus.stat_we) begin
                bus.unsecure_flag <= bus.wdata[`DSH_UNSECURE_FLAG_BIT];
            end
        end
    end

    // =====================================================================
    // Checks
    property p_trace_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.ce && bus.trace_set |=> bus.trace;
    endproperty
    a_trace_set: assert property (p_trace_set) else $error("trace flag not set");
endmodule // dsh_status

// ---- core/dsh_page.sv ----
// Program page index register for paged debug accesses
`timescale 1ns/1ps
`include "dsh_cfg.svh"
module dsh_page
    import dsh_pkg::*;
#(
    parameter int PAGE_W = `DSH_PAGE_IDX_W
)(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    dsh_reg_if.page   bus
);
    initial begin
        if (PAGE_W != 4) $error("page index width must be 4");
    end

    // Only the enable and the index are stored; bits 6..4 do not exist
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.page_en  <= 1'b0;
            bus.page_idx <= 4'h0;
        end else if (bus.ce && bus.page_we) begin
            bus.page_en  <= bus.wdata[`DSH_PAGE_EN_BIT];
            bus.page_idx <= bus.wdata[3:0];
        end
    end

    // =====================================================================
    // Checks
    property p_page_load;
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.ce && bus.page_we |=> bus.page_idx == $past(bus.wdata[3:0]);
    endproperty
    a_page_load: assert property (p_page_load) else $error("page index not loaded");
endmodule // dsh_page

// ---- core/dsh_top.sv ----
// Debug status, flags holding and page index registers with security walk
`timescale 1ns/1ps
`include "dsh_cfg.svh"
module dsh_top
    import dsh_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = `DSH_ADDR_W
)(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_ce,
    input  wire logic              i_special_mode,
    input  wire logic              i_flash_secure,
    input  wire logic              i_debug_reg_read_cmd,
    input  wire logic              i_debug_reg_write_cmd,
    input  wire logic              i_fw_read,
    input  wire logic              i_fw_write,
    input  wire logic              i_secure_fw,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_debug_enter,
    input  wire logic [DATA_W-1:0] i_cpu_flags,
    input  wire logic              i_single_step_cmd,
    input  wire logic              i_resume_cmd,
    input  wire logic              i_erase_done,
    input  wire logic              i_erase_blank,
    input  wire logic              i_global_access_enable,
    input  wire logic              i_debug_mem_access,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_rvalid,
    output logic                   o_trace,
    output logic                   o_unsecure_flag,
    output logic                   o_secured,
    output logic                   o_secure_table_en,
    output logic                   o_jump_standard,
    output logic                   o_global_access,
    output logic                   o_paged_access,
    output logic [3:0]             o_page_index_field
);
    initial begin
        if (DATA_W != 8) $error("data width must be 8");
        if (ADDR_W != 18) $error("address width must be 18");
    end

    // =====================================================================
    // Reset release
    logic rst_s1_reg;
    logic rst_n;

    // Two stages so release is clean against i_clk
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // =====================================================================
    // Mode straps
    logic init_reg;
    logic special_reg;
    logic fsec_reg;

    // Straps caught on the first enabled edge after release, never under reset
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_reg    <= 1'b0;
            special_reg <= 1'b0;
            fsec_reg    <= 1'b0;
        end else if (i_ce && !init_reg) begin
            init_reg    <= 1'b1;
            special_reg <= i_special_mode;
            fsec_reg    <= i_flash_secure;
        end
    end

    // =====================================================================
    // Register slices
    dsh_reg_if rif ();

    dsh_status u_status (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .bus     (rif.stat)
    );

    dsh_page u_page (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .bus     (rif.page)
    );

    // =====================================================================
    // Access decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic dbg_rd;
    logic dbg_wr;
    logic secured;
    logic open_acc;
    logic bd_cmd;

    // Only debug commands and debug firmware reach these registers
    assign dbg_rd   = i_debug_reg_read_cmd | i_fw_read;
    assign dbg_wr   = i_debug_reg_write_cmd | i_fw_write;
    assign bd_cmd   = i_debug_reg_read_cmd | i_debug_reg_write_cmd;
    // Not yet strapped counts as secured, so the first cycle leaks nothing
    assign secured  = !init_reg || (fsec_reg && !rif.unsecure_flag);
    assign open_acc = !secured;

    // =====================================================================
    // Security walk
    dsh_sec_state_t state_reg;
    dsh_sec_state_t state_next;
    logic           pass_evt;
    logic           fail_evt;

    assign pass_evt = (state_reg == DSH_S_VERIFY) && i_erase_done && i_erase_blank;
    assign fail_evt = (state_reg == DSH_S_VERIFY) && i_erase_done && !i_erase_blank;

    // Next state of the security walk
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DSH_S_INIT: begin
                if (!i_special_mode && i_flash_secure) begin
                    state_next = DSH_S_LOCK;
                end else if (i_flash_secure) begin
                    state_next = DSH_S_VERIFY;
                end else begin
                    state_next = DSH_S_OPEN;
                end
            end
            DSH_S_VERIFY: begin
                // Leave on the same edge the flag rises, so the secure table never overlaps an open flag
                if (pass_evt || (rif.stat_we && i_wdata[`DSH_UNSECURE_FLAG_BIT])) begin
                    state_next = DSH_S_UNSECURE_FLAG;
                end else if (fail_evt) begin
                    state_next = DSH_S_LOCK;
                end
            end
            DSH_S_UNSECURE_FLAG:  state_next = DSH_S_UNSECURE_FLAG;
            DSH_S_OPEN:   state_next = DSH_S_OPEN;
            DSH_S_LOCK:   state_next = DSH_S_LOCK;
            default:      state_next = DSH_S_INIT;
        endcase
    end

    // State moves only on enabled edges; init leaves with the strap capture
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= DSH_S_INIT;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Secure table overlays the standard one only while verifying
    assign o_secure_table_en = (state_reg == DSH_S_VERIFY);
    assign o_jump_standard   = pass_evt & i_ce;

    // =====================================================================
    // Strobes to the slices
    logic stat_wr_ok;

    // Secure firmware may only touch status in special mode while secured
    assign stat_wr_ok = open_acc || (i_secure_fw && i_fw_write && special_reg);
    assign rif.ce        = i_ce;
    assign rif.wdata     = i_wdata;
    assign rif.stat_we   = dbg_wr && hit(i_addr, `DSH_OFS_STATUS) && stat_wr_ok;
    assign rif.page_we   = dbg_wr && hit(i_addr, `DSH_OFS_PAGE) && open_acc;
    assign rif.trace_set = i_single_step_cmd;
    assign rif.trace_clr = i_resume_cmd;
    assign rif.unsecure_flag_set = pass_evt;

    // =====================================================================
    // Flags holding register
    logic [DATA_W-1:0] flags_holding_reg;
    logic              hold_we;

    assign hold_we = dbg_wr && hit(i_addr, `DSH_OFS_HOLD) && open_acc;

    // Debug entry capture wins over a write in the same cycle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_holding_reg <= `DSH_HOLD_RST_OTH;
        end else if (i_ce) begin
            if (!init_reg) begin
                // Mode-dependent value, not the CPU's own d0
                flags_holding_reg <= i_special_mode ? `DSH_HOLD_RST_SPC : `DSH_HOLD_RST_OTH;
            end else if (i_debug_enter) begin
                flags_holding_reg <= i_cpu_flags;
            end else if (hold_we) begin
                flags_holding_reg <= i_wdata;
            end
        end
    end

    // =====================================================================
    // Read path
    logic [DATA_W-1:0] rd_next;

    // Status is always visible to debug; the others hide while secured
    always_comb begin
        rd_next = '0;
        if (hit(i_addr, `DSH_OFS_STATUS)) begin
            rd_next[`DSH_TRACE_BIT] = rif.trace;
            rd_next[`DSH_UNSECURE_FLAG_BIT] = rif.unsecure_flag;
        end else if (hit(i_addr, `DSH_OFS_HOLD) && open_acc) begin
            rd_next = flags_holding_reg;
        end else if (hit(i_addr, `DSH_OFS_PAGE) && open_acc) begin
            rd_next = {rif.page_en, 3'h0, rif.page_idx};
        end
    end

    // Data one edge after the request; user reads never get here
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata  <= '0;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= dbg_rd;
            if (dbg_rd) begin
                o_rdata <= rd_next;
            end
        end
    end

    // =====================================================================
    // Memory access steering
    // Register commands must stay local even with global access enabled
    assign o_global_access    = i_global_access_enable && !bd_cmd;
    assign o_paged_access     = i_debug_mem_access && rif.page_en;
    assign o_page_index_field = rif.page_idx;

    assign o_trace         = rif.trace;
    assign o_unsecure_flag = rif.unsecure_flag;
    assign o_secured       = secured;

    // =====================================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    property p_trace_hold;
        i_ce && rif.trace && !i_resume_cmd && !rif.stat_we |=> rif.trace;
    endproperty
    a_trace_hold: assert property (p_trace_hold) else $error("trace flag dropped early");

    property p_trace_clear;
        i_ce && i_resume_cmd && !i_single_step_cmd && !rif.stat_we |=> !rif.trace;
    endproperty
    a_trace_clear: assert property (p_trace_clear) else $error("trace flag not cleared");

    property p_unsecure_flag_guard;
        init_reg && fsec_reg && !rif.unsecure_flag && !(i_secure_fw && special_reg) |-> !rif.stat_we;
    endproperty
    a_unsecure_flag_guard: assert property (p_unsecure_flag_guard) else $error("status written while secured");

    property p_secure_entry;
        state_reg == DSH_S_VERIFY && !rif.stat_we |-> !rif.unsecure_flag && o_secure_table_en;
    endproperty
    a_secure_entry: assert property (p_secure_entry) else $error("secure entry with flag set");

    property p_pass;
        i_ce && pass_evt |-> o_jump_standard ##1 (rif.unsecure_flag && !o_secure_table_en && !o_secured);
    endproperty
    a_pass: assert property (p_pass) else $error("erased flash did not unsecure");

    property p_fail;
        i_ce && fail_evt && !rif.stat_we |=> state_reg == DSH_S_LOCK && !rif.unsecure_flag && o_secured;
    endproperty
    a_fail: assert property (p_fail) else $error("failed verify unsecured device");

    property p_capture;
        i_ce && init_reg && i_debug_enter |=> flags_holding_reg == $past(i_cpu_flags);
    endproperty
    a_capture: assert property (p_capture) else $error("flags not captured on entry");

    property p_hold_reset;
        $rose(init_reg) |-> flags_holding_reg == (special_reg ? 8'hd8 : 8'h00);
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("holding reset value wrong");

    property p_locked_read;
        i_ce && dbg_rd && secured && !hit(i_addr, `DSH_OFS_STATUS) |=> o_rvalid && o_rdata == 8'h00;
    endproperty
    a_locked_read: assert property (p_locked_read) else $error("secured read leaked data");

    property p_no_global;
        bd_cmd |-> !o_global_access;
    endproperty
    a_no_global: assert property (p_no_global) else $error("register command went global");

    property p_page_read;
        i_ce && dbg_rd && open_acc && hit(i_addr, `DSH_OFS_PAGE) |=> o_rdata[6:4] == 3'h0;
    endproperty
    a_page_read: assert property (p_page_read) else $error("page unused bits not zero");

    // Status reads show only the trace and unsecure bits, secured or not
    property p_status_read;
        i_ce && dbg_rd && hit(i_addr, `DSH_OFS_STATUS)
        |=> o_rvalid && o_rdata == {4'h0, $past(rif.trace), 1'b0, $past(rif.unsecure_flag), 1'b0};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // An open write lands unless a debug entry capture takes the cycle
    property p_hold_write;
        i_ce && init_reg && hold_we && !i_debug_enter |=> flags_holding_reg == $past(i_wdata);
    endproperty
    a_hold_write: assert property (p_hold_write) else $error("holding write lost");

    // No holding or page strobe may leave the decoder while locked
    property p_locked_write;
        secured |-> !hold_we && !rif.page_we;
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("write strobe while secured");

    // Paging off means debug memory accesses stay unpaged
    property p_unpaged;
        i_debug_mem_access && !rif.page_en |-> !o_paged_access;
    endproperty
    a_unpaged: assert property (p_unpaged) else $error("paged access with paging off");

    // Enable low freezes every register of the block except the two reset release flops
    property p_ce_freeze;
        !i_ce |=> $stable(rif.trace) && $stable(rif.unsecure_flag) && $stable(flags_holding_reg)
                  && $stable(state_reg) && $stable(init_reg) && $stable(o_rvalid) && $stable(o_rdata);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

    c_pass:    cover property (i_ce && pass_evt);
    c_fail:    cover property (i_ce && fail_evt);
    c_trace:   cover property (rif.trace ##1 !rif.trace);
    c_hold_wr: cover property (i_ce && hold_we);
    c_fw_open: cover property (i_ce && rif.stat_we && i_secure_fw);
endmodule // dsh_top

// ---- verification/dsh_host_model.sv ----
// Debug host model issuing register accesses into the debug register slice
`timescale 1ns/1ps
module dsh_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_global_access,
    input  wire logic [7:0]  i_rdata,
    input  wire logic        i_rvalid,
    output logic             o_rd_cmd,
    output logic             o_wr_cmd,
    output logic             o_fw_write,
    output logic             o_secure_fw,
    output logic [17:0]      o_addr,
    output logic [7:0]       o_wdata
);
    // =====================================================================
    // Idle bus
    initial begin
        o_rd_cmd    = 1'b0;
        o_wr_cmd    = 1'b0;
        o_fw_write  = 1'b0;
        o_secure_fw = 1'b0;
        o_addr      = 18'h00000;
        o_wdata     = 8'h00;
    end

    // Drop strobes; invert address and data so stale values never look valid
    task automatic release_bus();
        o_rd_cmd    <= 1'b0;
        o_wr_cmd    <= 1'b0;
        o_fw_write  <= 1'b0;
        o_secure_fw <= 1'b0;
        o_addr      <= ~o_addr;
        o_wdata     <= ~o_wdata;
    endtask

    // =====================================================================
    // One-cycle write; secure picks the secure firmware write path
    task automatic wr(input logic secure, input logic [17:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_wr_cmd    <= ~secure;
        o_fw_write  <= secure;
        o_secure_fw <= secure;
        o_addr      <= addr;
        o_wdata     <= data;
        @(posedge i_clk);
        release_bus();
    endtask

    // One-cycle read; global access sampled while the command is up
    task automatic rd(input logic [17:0] addr, output logic [7:0] data, output logic vld, output logic ga);
        @(posedge i_clk);
        o_rd_cmd <= 1'b1;
        o_addr   <= addr;
        #1 ga = i_global_access;
        @(posedge i_clk);
        release_bus();
        #1 vld = i_rvalid;
        data = i_rdata;
    endtask
endmodule // dsh_host_model

// ---- verification/test_dsh_top.sv ----
// Self-checking bench for the debug status holding registers
`timescale 1ns/1ps
module test_dsh_top;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        special = 1'b0;
    logic        fsec = 1'b0;
    logic        blank = 1'b0;
    logic        gae = 1'b1;
    logic        mem_acc = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  cpu_flags = 8'h00;
    logic [3:0]  evt = 4'h0;
    logic        rd_cmd, wr_cmd, fw_wr, sec_fw, rvalid, trace, unsecure_flag, secured, tbl, jump, ga, paged, j;
    logic [17:0] addr;
    logic [7:0]  wdata, rdata;
    logic [3:0]  pidx;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;

    // =====================================================================
    // Clock, 100 MHz
    always #5 i_clk = ~i_clk;

    dsh_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_special_mode(special),
        .i_flash_secure(fsec), .i_debug_reg_read_cmd(rd_cmd), .i_debug_reg_write_cmd(wr_cmd),
        .i_fw_read(1'b0), .i_fw_write(fw_wr), .i_secure_fw(sec_fw), .i_addr(addr), .i_wdata(wdata),
        .i_debug_enter(evt[0]), .i_cpu_flags(cpu_flags), .i_single_step_cmd(evt[1]),
        .i_resume_cmd(evt[2]), .i_erase_done(evt[3]), .i_erase_blank(blank),
        .i_global_access_enable(gae), .i_debug_mem_access(mem_acc), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_trace(trace), .o_unsecure_flag(unsecure_flag), .o_secured(secured), .o_secure_table_en(tbl),
        .o_jump_standard(jump), .o_global_access(ga), .o_paged_access(paged), .o_page_index_field(pidx));

    dsh_host_model u_host (.i_clk(i_clk), .i_global_access(ga), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_rd_cmd(rd_cmd), .o_wr_cmd(wr_cmd), .o_fw_write(fw_wr), .o_secure_fw(sec_fw),
        .o_addr(addr), .o_wdata(wdata));

    // =====================================================================
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard; whole run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read through the host; command cycles must never reach global space
    task automatic rdchk(input logic [17:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        logic       g;
        u_host.rd(a, d, v, g);
        chk({7'h00, v}, 8'h01);
        chk({7'h00, g}, 8'h00);
        chk(d, exp);
    endtask

    // Reset held ten cycles, straps set, then time for the two-flop release
    task automatic do_reset(input logic spc, input logic sec);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        special  <= spc;
        fsec     <= sec;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_clk);
        #1;
    endtask

    // One-cycle event pulse; jump output captured in the pulse cycle
    task automatic pulse(input logic [3:0] e, output logic jmp);
        @(posedge i_clk);
        evt <= e;
        #1 jmp = jump;
        @(posedge i_clk);
        evt <= 4'h0;
        #1;
    endtask

    // =====================================================================
    // Scenarios
    initial begin
        // Normal mode, flash open
        do_reset(1'b0, 1'b0);
        chk({7'h00, secured}, 8'h00);
        chk({7'h00, ga}, 8'h01);
        rdchk(18'h3ff06, 8'h00);
        u_host.wr(1'b0, 18'h3ff06, 8'h5a);
        rdchk(18'h3ff06, 8'h5a);
        cpu_flags <= 8'h3c;
        pulse(4'h1, j);
        rdchk(18'h3ff06, 8'h3c);
        mem_acc <= 1'b1;
        u_host.wr(1'b0, 18'h3ff08, 8'hff);
        rdchk(18'h3ff08, 8'h8f);
        chk({4'h0, pidx}, 8'h0f);
        chk({7'h00, paged}, 8'h01);
        u_host.wr(1'b0, 18'h3ff08, 8'h05);
        #1 chk({7'h00, paged}, 8'h00);
        chk({4'h0, pidx}, 8'h05);
        pulse(4'h2, j);
        chk({7'h00, trace}, 8'h01);
        rdchk(18'h3ff01, 8'h08);
        pulse(4'h4, j);
        chk({7'h00, trace}, 8'h00);
        // Enable low: a single-step must not reach the frozen flag
        ce <= 1'b0;
        pulse(4'h2, j);
        chk({7'h00, trace}, 8'h00);
        ce <= 1'b1;
        rdchk(18'h3ff0a, 8'h00);
        // Special mode, secured, erase verify fails
        do_reset(1'b1, 1'b1);
        chk({7'h00, secured}, 8'h01);
        chk({7'h00, tbl}, 8'h01);
        chk({7'h00, unsecure_flag}, 8'h00);
        rdchk(18'h3ff06, 8'h00);
        rdchk(18'h3ff01, 8'h00);
        u_host.wr(1'b0, 18'h3ff01, 8'h02);
        #1 chk({7'h00, unsecure_flag}, 8'h00);
        blank <= 1'b0;
        pulse(4'h8, j);
        chk({7'h00, j}, 8'h00);
        chk({7'h00, unsecure_flag}, 8'h00);
        chk({7'h00, secured}, 8'h01);
        // Special mode, secured, flash erased
        do_reset(1'b1, 1'b1);
        blank <= 1'b1;
        pulse(4'h8, j);
        chk({7'h00, j}, 8'h01);
        chk({7'h00, unsecure_flag}, 8'h01);
        chk({7'h00, tbl}, 8'h00);
        chk({7'h00, secured}, 8'h00);
        rdchk(18'h3ff01, 8'h02);
        rdchk(18'h3ff06, 8'hd8);
        // Next reset secures again; secure firmware write opens it
        do_reset(1'b1, 1'b1);
        chk({7'h00, secured}, 8'h01);
        chk({7'h00, unsecure_flag}, 8'h00);
        u_host.wr(1'b1, 18'h3ff01, 8'h02);
        #1 chk({7'h00, unsecure_flag}, 8'h01);
        complete_run();
    end
endmodule // test_dsh_top
